// >>> shared/usart_rx_pkg.sv
// Package: register map, field positions, reset values and timing for the receive control
// Function
// R01: Serial port enable and both pin direction bits must be set before pins act.
// R02: Nine-bit select one takes nine data bits per character, zero takes eight.
// R03: Single receive ignored except synchronous master; there it starts one, self-clears.
// R04: Asynchronous mode: continuous receive enable turns continuous reception on or off.
// R05: Synchronous continuous reception runs until cleared and overrides single receive.
// R06: Receive control bit 3 is unimplemented and always reads zero.
// R07: Framing flag set on error; cleared only by buffer read plus next valid byte.
// R08: Overrun flag set on overrun; cleared when software clears continuous receive.
// R09: Ninth received bit is captured with the byte entering the receive buffer.
// R10: Baud generator is a free-running 8-bit timer whose period the divisor sets.
// R11: High-speed select affects only asynchronous mode; ignored in synchronous mode.
// R12: Asynchronous low speed: rate is oscillator over 64 times divisor plus one.
// R13: Asynchronous high speed: rate is oscillator over 16 times divisor plus one.
// R14: Synchronous mode: rate is oscillator over 4 times divisor plus one.
// R15: Divisor formulas apply only as master; slave takes its clock from outside.
// R16: Any divisor write immediately restarts the baud timer.
// R17: Software may prefer high-speed asynchronous mode for a smaller rate error.
// R18: Receive pin sampled three times mid-bit, level decided by majority vote.
// R19: Asynchronous generator output runs at 16 or 64 times the bit rate.
`default_nettype none
package usart_rx_pkg;
    // Register indices; byte address is four times the index
    localparam logic [11:0] RCS_IDX    = 12'h018;
    localparam logic [11:0] TCS_IDX    = 12'h098;
    localparam logic [11:0] DIV_IDX    = 12'h099;
    localparam logic [11:0] RBUF_IDX   = 12'h019;
    localparam logic [11:0] STAT_IDX   = 12'h020;
    localparam logic [11:0] MASK_IDX   = 12'h021;
    localparam logic [11:0] PINDIR_IDX = 12'h022;
    localparam logic [11:0] RCS_ADDR    = RCS_IDX << 2;
    localparam logic [11:0] TCS_ADDR    = TCS_IDX << 2;
    localparam logic [11:0] DIV_ADDR    = DIV_IDX << 2;
    localparam logic [11:0] RBUF_ADDR   = RBUF_IDX << 2;
    localparam logic [11:0] STAT_ADDR   = STAT_IDX << 2;
    localparam logic [11:0] MASK_ADDR   = MASK_IDX << 2;
    localparam logic [11:0] PINDIR_ADDR = PINDIR_IDX << 2;
    // Receive control/status fields
    localparam int RCS_PORT_EN = 7;
    localparam int RCS_NINE    = 6;
    localparam int RCS_SINGLE  = 5;
    localparam int RCS_CONT    = 4;
    // Transmit control/status fields
    localparam int TCS_CSRC = 7;
    localparam int TCS_TX9  = 6;
    localparam int TCS_TXEN = 5;
    localparam int TCS_SYNC = 4;
    localparam int TCS_FAST = 2;
    localparam int TCS_TX9D = 0;
    // Interrupt status bits
    localparam int INT_RXRDY = 0;
    localparam int INT_FRAME = 1;
    localparam int INT_OVRUN = 2;
    localparam int INT_BITS  = 3;
    // Reset values
    localparam logic [7:0] RCS_RESET = 8'h00;
    localparam logic [7:0] TCS_RESET = 8'h02;
    localparam logic [7:0] DIV_RESET = 8'h00;
    // Oversampling: 16 phases per bit, majority at phases 7, 8, 9
    localparam logic [3:0] PH_SAMPLE_A = 4'h7;
    localparam logic [3:0] PH_SAMPLE_B = 4'h8;
    localparam logic [3:0] PH_DECIDE   = 4'h9;
    // Prescaler phase that ends a group of four generator ticks
    localparam logic [1:0] PRE_LAST    = 2'h3;
    localparam logic [1:0] PRE_RISE    = 2'h1;
    localparam logic [3:0] BITS_EIGHT  = 4'h8;
    localparam logic [3:0] BITS_NINE   = 4'h9;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP, ST_FINISH} rx_state_t;
endpackage : usart_rx_pkg
`default_nettype wire

// >>> design/usart_baud_and_receive_control.sv
// Baud generator and receive control/status logic with an AXI4-Lite register slave
`default_nettype none
module usart_baud_and_receive_control (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // AXI4-Lite write address and data
    input  wire logic        s_axi_awvalid_in,
    output var  logic        s_axi_awready_out,
    input  wire logic [11:0] s_axi_awaddr_in,
    input  wire logic        s_axi_wvalid_in,
    output var  logic        s_axi_wready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    // AXI4-Lite write response
    output var  logic        s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    output var  logic [1:0]  s_axi_bresp_out,
    // AXI4-Lite read
    input  wire logic        s_axi_arvalid_in,
    output var  logic        s_axi_arready_out,
    input  wire logic [11:0] s_axi_araddr_in,
    output var  logic        s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    output var  logic [31:0] s_axi_rdata_out,
    output var  logic [1:0]  s_axi_rresp_out,
    // Serial pins
    input  wire logic        receive_data_pin_in,
    input  wire logic        transmit_clock_pin_in,
    output var  logic        transmit_clock_pin_out,
    output var  logic        transmit_clock_pin_oe_out,
    // Interrupt
    output var  logic        irq_out
);
    import usart_rx_pkg::*;

    // Register state
    logic       port_en_reg, nine_sel_reg, single_reg, cont_reg;
    logic       frame_err_reg, ovr_err_reg, ninth_reg;
    logic       csrc_reg, tx9_reg, txen_reg, sync_reg, fast_reg, tx9d_reg;
    logic [7:0] div_reg, rbuf_reg;
    logic       rbuf_full_reg;
    logic [1:0] pin_dir_reg;
    logic [INT_BITS-1:0] int_stat_reg, int_mask_reg;
    // Bus state
    logic        awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0]  bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic        rd_was_rcs_reg;
    // Baud and receiver state
    logic [7:0] baud_cnt_reg;
    logic [1:0] pre_cnt_reg;
    logic       rx_s1_reg, rx_s2_reg, ck_s1_reg, ck_s2_reg, ck_s3_reg;
    logic       s_a_reg, s_b_reg;
    logic [3:0] phase_reg, bit_cnt_reg;
    logic [8:0] shreg_reg;
    rx_state_t  state_reg, state_next;
    logic [3:0] phase_next, bit_cnt_next;
    logic [8:0] shreg_next;
    logic       clk_pin_reg, clk_oe_reg, irq_reg;

    // Bus decode
    wire wr_fire  = s_axi_awvalid_in && s_axi_wvalid_in && !awready_reg && !bvalid_reg;
    wire wr_lane  = wr_fire && s_axi_wstrb_in[0];
    wire wr_rcs   = wr_lane && (s_axi_awaddr_in == RCS_ADDR);
    wire wr_tcs   = wr_lane && (s_axi_awaddr_in == TCS_ADDR);
    wire wr_div   = wr_lane && (s_axi_awaddr_in == DIV_ADDR);
    wire wr_stat  = wr_lane && (s_axi_awaddr_in == STAT_ADDR);
    wire wr_mask  = wr_lane && (s_axi_awaddr_in == MASK_ADDR);
    wire wr_pin   = wr_lane && (s_axi_awaddr_in == PINDIR_ADDR);
    wire wr_hit   = (s_axi_awaddr_in == RCS_ADDR) || (s_axi_awaddr_in == TCS_ADDR) ||
                    (s_axi_awaddr_in == DIV_ADDR) || (s_axi_awaddr_in == STAT_ADDR) ||
                    (s_axi_awaddr_in == MASK_ADDR) || (s_axi_awaddr_in == PINDIR_ADDR) ||
                    (s_axi_awaddr_in == RBUF_ADDR);
    wire [7:0] wbyte = s_axi_wdata_in[7:0];
    wire rd_fire  = s_axi_arvalid_in && !arready_reg && !rvalid_reg;
    wire rd_rbuf  = rd_fire && (s_axi_araddr_in == RBUF_ADDR);

    // Readback views; unimplemented bit 3 is a constant zero, transmit-empty reads one
    wire [7:0] rcs_view = {port_en_reg, nine_sel_reg, single_reg, cont_reg, 1'b0,
                           frame_err_reg, ovr_err_reg, ninth_reg};    // see R06
    wire [7:0] tcs_view = {csrc_reg, tx9_reg, txen_reg, sync_reg, 1'b0,
                           fast_reg, 1'b1, tx9d_reg};
    wire       rd_hit   = (s_axi_araddr_in == RCS_ADDR) || (s_axi_araddr_in == TCS_ADDR) ||
                          (s_axi_araddr_in == DIV_ADDR) || (s_axi_araddr_in == RBUF_ADDR) ||
                          (s_axi_araddr_in == STAT_ADDR) || (s_axi_araddr_in == MASK_ADDR) ||
                          (s_axi_araddr_in == PINDIR_ADDR);
    wire [7:0] rd_byte  =
        (s_axi_araddr_in == RCS_ADDR)    ? rcs_view :
        (s_axi_araddr_in == TCS_ADDR)    ? tcs_view :
        (s_axi_araddr_in == DIV_ADDR)    ? div_reg :
        (s_axi_araddr_in == RBUF_ADDR)   ? rbuf_reg :
        (s_axi_araddr_in == STAT_ADDR)   ? {5'h00, int_stat_reg} :
        (s_axi_araddr_in == MASK_ADDR)   ? {5'h00, int_mask_reg} :
        (s_axi_araddr_in == PINDIR_ADDR) ? {6'h00, pin_dir_reg} : 8'h00;

    // Mode decode
    wire async_mode = !sync_reg;
    wire smaster    = sync_reg && csrc_reg;
    wire sslave     = sync_reg && !csrc_reg;
    wire pins_on    = port_en_reg && pin_dir_reg[1] && pin_dir_reg[0]; // see R01
    // Continuous overrides single; single counts only as synchronous master
    wire rx_en      = pins_on && !ovr_err_reg &&
                      (cont_reg || (smaster && single_reg));          // see R03 R04 R05

    // Baud timer: period divisor+1, restarted by any divisor write
    wire baud_tick  = (baud_cnt_reg == div_reg);                      // see R10
    wire [7:0] baud_cnt_next = (wr_div || baud_tick) ? 8'h00 :
                               baud_cnt_reg + 8'h01;                   // see R16
    wire [1:0] pre_cnt_next = wr_div ? 2'h0 :
                              baud_tick ? pre_cnt_reg + 2'h1 : pre_cnt_reg;
    // Oversample clock x16 from every tick (high speed) or every fourth (x64 total)
    wire sample_en  = async_mode && baud_tick &&
                      (fast_reg || (pre_cnt_reg == PRE_LAST));         // see R11 R12 R13 R19
    // Synchronous bit clock: four ticks per bit as master, pin edge as slave
    wire ck_rise    = ck_s2_reg && !ck_s3_reg;
    wire sync_bit   = smaster ? (baud_tick && (pre_cnt_reg == PRE_RISE)) :
                      (sslave && ck_rise);                             // see R14 R15

    // Majority of three mid-bit samples
    wire maj  = (s_a_reg && s_b_reg) || (s_a_reg && rx_s2_reg) ||
                (s_b_reg && rx_s2_reg);                                // see R18
    wire decide     = sample_en && (phase_reg == PH_DECIDE);
    wire [3:0] bits_need = nine_sel_reg ? BITS_NINE : BITS_EIGHT;      // see R02
    wire [3:0] bit_inc   = bit_cnt_reg + 4'h1;

    // Character completion and buffer hand-off
    wire done       = ((state_reg == ST_STOP) && decide) || (state_reg == ST_FINISH);
    wire stop_bad   = (state_reg == ST_STOP) && !maj;
    wire buf_busy   = rbuf_full_reg && !rd_rbuf;
    wire load       = done && !buf_busy;
    wire ovr        = done && buf_busy;
    wire [7:0] rx_byte  = nine_sel_reg ? shreg_reg[7:0] : shreg_reg[8:1];
    wire       rx_ninth = nine_sel_reg && shreg_reg[8];
    wire cont_clear = wr_rcs && !wbyte[RCS_CONT] && cont_reg;
    wire [INT_BITS-1:0] int_events = {ovr, load && stop_bad, load};
    wire [INT_BITS-1:0] int_clear  = wr_stat ? wbyte[INT_BITS-1:0] : {INT_BITS{1'b0}};

    // Receiver sequencing
    always_comb begin
        state_next   = state_reg;
        phase_next   = sample_en ? phase_reg + 4'h1 : phase_reg;
        bit_cnt_next = bit_cnt_reg;
        shreg_next   = shreg_reg;
        case (state_reg)
            ST_IDLE: begin
                bit_cnt_next = 4'h0;
                if (rx_en && async_mode && !rx_s2_reg) begin
                    state_next = ST_START;
                    phase_next = 4'h0;
                end else if (rx_en && sync_reg) begin
                    state_next = ST_DATA;
                end
            end
            ST_START: begin
                if (decide) begin
                    state_next = maj ? ST_IDLE : ST_DATA;              // False start rejected
                end
            end
            ST_DATA: begin
                if ((async_mode && decide) || (sync_reg && sync_bit)) begin
                    shreg_next   = {async_mode ? maj : rx_s2_reg, shreg_reg[8:1]};
                    bit_cnt_next = bit_inc;
                    if (bit_inc == bits_need) begin                    // see R02
                        state_next = async_mode ? ST_STOP : ST_FINISH;
                    end
                end
            end
            ST_STOP: begin
                if (decide) begin
                    state_next = ST_IDLE;
                end
            end
            ST_FINISH: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // Disable or mode loss drops a partial character
        if (!rx_en) begin
            state_next = ST_IDLE;
        end
    end

    // Receiver registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg   <= ST_IDLE;
            phase_reg   <= 4'h0;
            bit_cnt_reg <= 4'h0;
            shreg_reg   <= 9'h000;
            s_a_reg     <= 1'b1;
            s_b_reg     <= 1'b1;
        end else begin
            state_reg   <= state_next;
            phase_reg   <= phase_next;
            bit_cnt_reg <= bit_cnt_next;
            shreg_reg   <= shreg_next;
            if (sample_en && (phase_reg == PH_SAMPLE_A)) s_a_reg <= rx_s2_reg;  // see R18
            if (sample_en && (phase_reg == PH_SAMPLE_B)) s_b_reg <= rx_s2_reg;
        end
    end

    // Pin synchronisers; third clock stage only feeds the slave edge detector
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            {rx_s1_reg, rx_s2_reg} <= 2'b11;
            {ck_s1_reg, ck_s2_reg, ck_s3_reg} <= 3'b000;
        end else begin
            {rx_s1_reg, rx_s2_reg} <= {receive_data_pin_in, rx_s1_reg};
            {ck_s1_reg, ck_s2_reg, ck_s3_reg} <= {transmit_clock_pin_in, ck_s1_reg, ck_s2_reg};
        end
    end

    // Baud timer never stops; rate changes land without waiting for wrap
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            baud_cnt_reg <= 8'h00;
            pre_cnt_reg <= 2'h0;
        end else begin
            baud_cnt_reg <= baud_cnt_next;                             // see R10 R16
            pre_cnt_reg <= pre_cnt_next;
        end
    end

    // Master drives the bit clock, half high per bit; slave leaves the pin alone
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            clk_pin_reg <= 1'b0;
            clk_oe_reg  <= 1'b0;
        end else begin
            clk_pin_reg <= smaster && rx_en && pre_cnt_reg[1];        // see R14 R15
            clk_oe_reg  <= smaster && pins_on;                         // see R01
        end
    end

    // Control registers written by software
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            {port_en_reg, nine_sel_reg, cont_reg} <= {RCS_RESET[7], RCS_RESET[6], RCS_RESET[4]};
            {csrc_reg, tx9_reg, txen_reg, sync_reg} <= TCS_RESET[7:4];
            {fast_reg, tx9d_reg} <= {TCS_RESET[2], TCS_RESET[0]};
            div_reg      <= DIV_RESET;
            pin_dir_reg  <= 2'h0;
            int_mask_reg <= {INT_BITS{1'b0}};
        end else begin
            if (wr_rcs) begin
                {port_en_reg, nine_sel_reg} <= {wbyte[RCS_PORT_EN], wbyte[RCS_NINE]};
                cont_reg <= wbyte[RCS_CONT];                           // see R04
            end
            if (wr_tcs) begin
                {csrc_reg, tx9_reg} <= {wbyte[TCS_CSRC], wbyte[TCS_TX9]};
                {txen_reg, sync_reg} <= {wbyte[TCS_TXEN], wbyte[TCS_SYNC]};
                {fast_reg, tx9d_reg} <= {wbyte[TCS_FAST], wbyte[TCS_TX9D]};
            end
            if (wr_div)  div_reg      <= wbyte;
            if (wr_pin)  pin_dir_reg  <= wbyte[1:0];
            if (wr_mask) int_mask_reg <= wbyte[INT_BITS-1:0];
        end
    end

    // Single receive self-clears after a master character unless continuous is on
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            single_reg <= RCS_RESET[5];
        end else if (wr_rcs) begin
            single_reg <= wbyte[RCS_SINGLE];
        end else if (done && smaster && !cont_reg) begin
            single_reg <= 1'b0;                                        // see R03 R05
        end
    end

    // Receive buffer, ninth bit and error flags; software cannot write them
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rbuf_reg      <= 8'h00;
            rbuf_full_reg <= 1'b0;
            ninth_reg     <= 1'b0;
            frame_err_reg <= 1'b0;
            ovr_err_reg   <= 1'b0;
        end else begin
            if (load) begin
                rbuf_reg      <= rx_byte;
                ninth_reg     <= rx_ninth;                             // see R09
                frame_err_reg <= stop_bad;                             // see R07
            end
            rbuf_full_reg <= load || buf_busy;
            // Overrun set wins over a same-cycle clear
            if (ovr)             ovr_err_reg <= 1'b1;                  // see R08
            else if (cont_clear) ovr_err_reg <= 1'b0;                  // see R08
        end
    end

    // Sticky interrupt status, write one to clear, new events win
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            int_stat_reg <= {INT_BITS{1'b0}};
            irq_reg      <= 1'b0;
        end else begin
            int_stat_reg <= (int_stat_reg & ~int_clear) | int_events;
            irq_reg      <= |(int_stat_reg & int_mask_reg);
        end
    end

    // AXI write: address and data taken together, response the next cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            {awready_reg, wready_reg, bvalid_reg} <= 3'b000;
            bresp_reg <= RESP_OKAY;
        end else begin
            awready_reg <= wr_fire;
            wready_reg  <= wr_fire;
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready_in) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // AXI read: data registered at the accepting edge
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            {arready_reg, rvalid_reg, rd_was_rcs_reg} <= 3'b000;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else begin
            arready_reg <= rd_fire;
            if (rd_fire) begin
                rvalid_reg     <= 1'b1;
                rdata_reg      <= {24'h00_0000, rd_byte};
                rresp_reg      <= rd_hit ? RESP_OKAY : RESP_SLVERR;
                rd_was_rcs_reg <= (s_axi_araddr_in == RCS_ADDR);
            end else if (s_axi_rready_in) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // Output drive, all from flip-flops
    assign s_axi_awready_out         = awready_reg;
    assign s_axi_wready_out          = wready_reg;
    assign s_axi_bvalid_out          = bvalid_reg;
    assign s_axi_bresp_out           = bresp_reg;
    assign s_axi_arready_out         = arready_reg;
    assign s_axi_rvalid_out          = rvalid_reg;
    assign s_axi_rdata_out           = rdata_reg;
    assign s_axi_rresp_out           = rresp_reg;
    assign transmit_clock_pin_out    = clk_pin_reg;
    assign transmit_clock_pin_oe_out = clk_oe_reg;
    assign irq_out                   = irq_reg;

    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    bit3_reads_zero_a: assert property (rvalid_reg && rd_was_rcs_reg |-> !rdata_reg[3]) // see R06
        else $error("receive control bit 3 read as one");
    divisor_restart_a: assert property (wr_div |=> baud_cnt_reg == 8'h00) // see R16
        else $error("baud timer not restarted by divisor write");
    baud_period_a: assert property (baud_tick && div_reg == 8'h01 && !wr_div ##1 !wr_div
                                    |=> baud_tick) // see R10
        else $error("baud tick period differs from divisor plus one");
    single_ignored_a: assert property (done && !smaster && !wr_rcs |=> single_reg == $past(single_reg)) // see R03
        else $error("single receive changed outside synchronous master");
    single_clear_a: assert property (done && smaster && single_reg && !cont_reg && !wr_rcs
                                     |=> !single_reg) // see R03
        else $error("single receive not cleared after character");
    cont_priority_a: assert property (done && cont_reg && !wr_rcs |=> single_reg == $past(single_reg)) // see R05
        else $error("single receive cleared while continuous on");
    overrun_set_a: assert property (done && rbuf_full_reg && !rd_rbuf |=> ovr_err_reg && !rx_en) // see R08
        else $error("overrun not flagged");
    overrun_clear_a: assert property (cont_clear && !ovr |=> !ovr_err_reg) // see R08
        else $error("overrun not cleared with continuous receive");
    ninth_bit_a: assert property (load && nine_sel_reg |=> ninth_reg == $past(shreg_reg[8])) // see R09
        else $error("ninth bit not captured with byte");
    frame_flag_a: assert property (load |=> frame_err_reg == $past(stop_bad) && rbuf_full_reg) // see R07
        else $error("framing flag mismatch on load");
    char_width_a: assert property (done |-> bit_cnt_reg == bits_need) // see R02
        else $error("character width wrong");
    sample_rate_a: assert property (async_mode && fast_reg |-> sample_en == baud_tick) // see R13 R19
        else $error("high speed oversample rate wrong");
    slow_rate_a: assert property (sample_en && !fast_reg |-> pre_cnt_reg == PRE_LAST) // see R12
        else $error("low speed oversample rate wrong");

    async_char_c: cover property (load && async_mode && !stop_bad);
    frame_err_c:  cover property (load && stop_bad);
    overrun_c:    cover property (ovr);
    master_rx_c:  cover property (done && smaster && single_reg && !cont_reg);
endmodule : usart_baud_and_receive_control
`default_nettype wire

// >>> tb/serial_source.sv
// Serial source model: asynchronous frames onto the receive pin
`default_nettype none
module serial_source (
    // Clock and line
    input  wire logic clk_in,
    output var  logic line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line_out = 1'b1;
    // Start, LSB first data, short stop so a low stop cannot pose as a new start
    task automatic send(input logic [8:0] d, input int n, input logic stp, input int per);
        for (int k = 0; k <= n + 1; k++) begin
            @(posedge clk_in);
            line_out <= (k == 0) ? 1'b0 : (k > n) ? stp : d[k-1];
            repeat ((k > n) ? per * 3 / 4 - 1 : per - 1) @(posedge clk_in);
        end
        line_out <= 1'b1;
    endtask : send
endmodule : serial_source
`default_nettype wire

// >>> tb/tb_usart_baud_and_receive_control.sv
// Bench: registers, reception, error flags and interrupt
`default_nettype none
module tb_usart_baud_and_receive_control;
    import usart_rx_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 0, rst_in = 1, aw = 0, w = 0, bq = 0, ar = 0, rq = 0;
    logic        irq, rx, awr, wrd, bv, arr, rv, oe;
    logic [1:0]  br, rr, rs;
    logic [11:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd, rdat;
    logic [7:0]  rnd = 8'h1A;
    int          err_count = 0, samples_checked = 0, t = 0, i;
    // Slave clock input idle: of the synchronous modes only master is exercised
    usart_baud_and_receive_control u_usart_baud_and_receive_control (
        .clk_in, .rst_in, .s_axi_awvalid_in(aw), .s_axi_awready_out(awr),
        .s_axi_awaddr_in(awa), .s_axi_wvalid_in(w), .s_axi_wready_out(wrd),
        .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(bq), .s_axi_bresp_out(br), .s_axi_arvalid_in(ar),
        .s_axi_arready_out(arr), .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv),
        .s_axi_rready_in(rq), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr),
        .receive_data_pin_in(rx), .transmit_clock_pin_in(1'b0),
        .transmit_clock_pin_out(), .transmit_clock_pin_oe_out(oe), .irq_out(irq));
    serial_source u_serial_source (.clk_in, .line_out(rx));
    // Clock, 10 ns period
    initial forever #5 clk_in = ~clk_in;
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
            err_count++;
        end
    endtask : chk
    // Bus master; starts one edge late so no signal is driven twice in a step
    task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_in);
        {aw, w, bq, ar, rq} <= {wr, wr, wr, !wr, !wr};
        awa <= a; ara <= a; wd <= {24'h0, d};
        do @(posedge clk_in); while ((wr ? awr : arr) !== 1'b1);
        {aw, w, ar} <= 3'b000;
        while ((wr ? bv : rv) !== 1'b1) @(posedge clk_in);
        {bq, rq} <= 2'b00;
        rd = rdat;
        rs = wr ? br : rr;
    endtask : bus
    task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        chk(rd & m, e);
    endtask : rc
    task automatic done;
        t++;
        $display("test %0d done", t);
    endtask : done
    task automatic final_report;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    // Watchdog well beyond the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge clk_in);
        err_count++;
        final_report;
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        rc(RCS_ADDR, 32'hFE, 32'h00);
        rc(TCS_ADDR, 32'hFF, 32'h02);
        rc(DIV_ADDR, 32'hFF, 32'h00);
        rc(12'hFFC, 32'hFF, 32'h00);
        chk(rs, RESP_SLVERR);
        bus(1, TCS_ADDR, 8'h04);
        bus(1, DIV_ADDR, 8'h01);
        bus(1, PINDIR_ADDR, 8'h03);
        bus(1, RCS_ADDR, 8'h98);
        rc(RCS_ADDR, 32'hF8, 32'h90);
        done;
        // Random bytes at 32 clocks a bit; the middle one masked
        for (i = 0; i < 3; i++) begin
            bus(1, MASK_ADDR, (i == 1) ? 8'h00 : 8'h07);
            chk(irq, 32'h0);
            rnd = lfsr(rnd);
            u_serial_source.send({1'b1, rnd}, 8, 1'b1, 32);
            rc(STAT_ADDR, 32'hFF, 32'h01);
            chk(irq, i != 1);
            rc(RBUF_ADDR, 32'hFF, rnd);
            bus(1, STAT_ADDR, 8'h07);
        end
        done;
        bus(1, RCS_ADDR, 8'hD0);
        rnd = lfsr(rnd);
        u_serial_source.send({1'b1, rnd}, 9, 1'b1, 32);
        rc(RCS_ADDR, 32'h01, 32'h01);
        rc(RBUF_ADDR, 32'hFF, rnd);
        done;
        // Framing flag survives a read alone; overrun cleared by continuous off
        bus(1, RCS_ADDR, 8'h90);
        u_serial_source.send(9'h05A, 8, 1'b0, 32);
        rc(RBUF_ADDR, 32'hFF, 32'h5A);
        rc(RCS_ADDR, 32'h04, 32'h04);
        u_serial_source.send(9'h0A5, 8, 1'b1, 32);
        rc(RCS_ADDR, 32'h04, 32'h00);
        u_serial_source.send(9'h011, 8, 1'b1, 32);
        rc(RCS_ADDR, 32'h02, 32'h02);
        bus(1, RCS_ADDR, 8'h80);
        rc(RCS_ADDR, 32'h02, 32'h00);
        rc(RBUF_ADDR, 32'hFF, 32'hA5);
        done;
        bus(1, TCS_ADDR, 8'h00);
        bus(1, DIV_ADDR, 8'h00);
        bus(1, RCS_ADDR, 8'h90);
        u_serial_source.send(9'h1C3, 8, 1'b1, 64);
        rc(RBUF_ADDR, 32'hFF, 32'hC3);
        done;
        // Synchronous master single receive of an idle-high line
        bus(1, RCS_ADDR, 8'h80);
        bus(1, TCS_ADDR, 8'h90);
        bus(1, RCS_ADDR, 8'hA0);
        repeat (60) @(posedge clk_in);
        chk(oe, 32'h1);
        rc(RCS_ADDR, 32'h20, 32'h00);
        rc(RBUF_ADDR, 32'hFF, 32'hFF);
        done;
        final_report;
    end
endmodule : tb_usart_baud_and_receive_control
`default_nettype wire
